// ==== spsc_defs.vh ====
// Purpose: Constants for the standby pin state controller
// Assumes: Machine clock drives core_clk_i
// Notes:   Mode codes are shared by the checker and the top
`ifndef SPSC_DEFS_VH
`define SPSC_DEFS_VH
// ==========================================================
// Operating modes
`define SPSC_MODE_W        2
`define SPSC_MODE_NORMAL   2'h0
`define SPSC_MODE_SLEEP    2'h1
`define SPSC_MODE_STOP     2'h2
`define SPSC_MODE_WATCH    2'h3
// ==========================================================
// Pin counts and timing
`define SPSC_GPIO_N        8
`define SPSC_IRQ_N         2
`define SPSC_MIN_PULSE_CLK 2
`endif

// ==== spsc_pad_model.sv ====
// Purpose: Board circuitry seen by the general pins
// Assumes: Board drives only pins the device releases
// Notes:   An open, unpulled pin wanders every cycle
`timescale 1ns/1ns
module spsc_pad_model (
  input  wire       clk_i,
  input  wire [7:0] oe_i, out_i, pu_i, ext_i,
  output wire [7:0] pad_o
);
  reg [7:0] flt_q = 8'h55;
  always @(posedge clk_i) flt_q <= ~flt_q;
  assign pad_o = (oe_i & out_i) | (~oe_i & ext_i) | (~oe_i & ~ext_i & (pu_i | flt_q));
endmodule

// ==== spsc_pin_cell.v ====
// Purpose: One general pin: drive, pull-up and input gating
// Assumes: Controls already resolved by the top
// Notes:   Purely combinational
`timescale 1ns/1ns
module spsc_pin_cell (
  input  wire dir_out_i,
  input  wire data_i,
  input  wire pullup_en_i,
  input  wire force_hiz_i,
  input  wire hold_i,
  input  wire hold_oe_i,
  input  wire hold_val_i,
  input  wire block_i,
  input  wire pad_in_i,
  output wire pad_out_o,
  output wire pad_oe_o,
  output wire pad_pullup_o,
  output wire core_in_o
);
  // ========================================================
  // Drive selection
  wire oe_live;
  assign oe_live      = hold_i ? hold_oe_i : dir_out_i;
  assign pad_oe_o     = force_hiz_i ? 1'b0 : oe_live;
  assign pad_out_o    = hold_i ? hold_val_i : data_i;
  // Pull-up stays while floated, drops when driving low
  assign pad_pullup_o = pullup_en_i & ~(pad_oe_o & ~pad_out_o);
  // Low-forced input stops leakage from an open pin
  assign core_in_o    = block_i ? 1'b0 : pad_in_i;
endmodule

// ==== spsc_top.v ====
// Purpose: Pin state control across normal, sleep, stop, watch and reset
// Assumes: Inputs synchronous to core_clk_i; mode code from clock controller
// Notes:   Held state is captured on the entry edge into stop or watch
//
// Summary of operation
// - Entering stop or watch with float select clear holds each pin's drive and blocks input.
// - Entering stop or watch with float select set floats each pin and blocks input.
// - Pull-up settings stay in force on pins floated in stop or watch.
// - Enabled external interrupt lines still reach the interrupt logic in stop or watch.
// - In reset pins float with inputs blocked, so no function acts on them.
// - Oscillator pins oscillate in normal and sleep and float in stop and watch.
// - The shared reset pin is a port in normal operation only, else the reset input.
// - In debug mode the debug pin is the single-wire line to the tool.
// - Float select lives in the standby control register and is sampled on entry.
// - A blocked input reads as low inside the device.
// - A pull-up drops whenever its pin drives low.
`timescale 1ns/1ns
`include "spsc_defs.vh"
module spsc_top #(
  parameter N = `SPSC_GPIO_N
) (
  input  wire                    core_clk_i,
  input  wire                    rst_n_i,
  input  wire [`SPSC_MODE_W-1:0] mode_i,
  input  wire                    standby_float_select_i,
  input  wire [N-1:0]            dir_out_i,
  input  wire [N-1:0]            data_i,
  input  wire [N-1:0]            pullup_en_i,
  input  wire [N-1:0]            osc_sel_i,
  input  wire [`SPSC_IRQ_N-1:0]  ext_irq_en_i,
  input  wire [N-1:0]            pad_in_i,
  output wire [N-1:0]            pad_out_o,
  output wire [N-1:0]            pad_oe_o,
  output wire [N-1:0]            pad_pullup_o,
  output wire [N-1:0]            port_in_o,
  output wire [N-1:0]            osc_in_o,
  output wire [`SPSC_IRQ_N-1:0]  ext_irq_o,
  input  wire                    shared_reset_pin_in_i,
  input  wire                    shared_reset_dir_i,
  input  wire                    shared_reset_data_i,
  output wire                    shared_reset_pin_out_o,
  output wire                    shared_reset_pin_oe_o,
  output wire                    shared_reset_port_in_o,
  output wire                    ext_reset_req_o,
  input  wire                    debug_mode_i,
  input  wire                    debug_wire_pin_in_i,
  input  wire                    debug_tx_i,
  input  wire                    debug_tx_en_i,
  output wire                    debug_wire_pin_out_o,
  output wire                    debug_wire_pin_oe_o,
  output wire                    debug_rx_o
);
  // ========================================================
  // Mode decode
  function is_standby;
    input [`SPSC_MODE_W-1:0] m;
    begin
      is_standby = (m == `SPSC_MODE_STOP) || (m == `SPSC_MODE_WATCH);
    end
  endfunction

  wire in_reset;
  wire standby;
  assign in_reset = ~rst_n_i;
  assign standby  = is_standby(mode_i);

  // ========================================================
  // Entry capture of float select and held drive
  reg         standby_q;
  reg         float_q;
  reg [N-1:0] hold_oe_q;
  reg [N-1:0] hold_val_q;
  wire        entry;
  assign entry = standby & ~standby_q;

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      standby_q  <= 1'b0;
      float_q    <= 1'b0;
      hold_oe_q  <= {N{1'b0}};
      hold_val_q <= {N{1'b0}};
    end else begin
      standby_q <= standby;
      if (entry) begin
        float_q    <= standby_float_select_i;
        hold_oe_q  <= dir_out_i;
        hold_val_q <= data_i;
      end
    end
  end

  // Entry cycle uses the live select so no cycle shows a stale state
  wire float_now;
  wire hold_now;
  wire blocked;
  assign float_now = entry ? standby_float_select_i : float_q;
  assign hold_now  = standby & ~entry & ~float_now;
  assign blocked   = standby | in_reset;

  // ========================================================
  // General pins
  wire [N-1:0] core_in;
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_pin
      spsc_pin_cell u_cell (
        .dir_out_i    (dir_out_i[g] & ~osc_sel_i[g]),
        .data_i       (data_i[g]),
        .pullup_en_i  (pullup_en_i[g] & ~osc_sel_i[g] & ~in_reset),
        .force_hiz_i  (in_reset | osc_sel_i[g] | (standby & float_now)),
        .hold_i       (hold_now),
        .hold_oe_i    (hold_oe_q[g]),
        .hold_val_i   (hold_val_q[g]),
        .block_i      (blocked | osc_sel_i[g]),
        .pad_in_i     (pad_in_i[g]),
        .pad_out_o    (pad_out_o[g]),
        .pad_oe_o     (pad_oe_o[g]),
        .pad_pullup_o (pad_pullup_o[g]),
        .core_in_o    (core_in[g])
      );
    end
  endgenerate
  assign port_in_o = core_in;
  // Oscillator input gated off in standby
  assign osc_in_o  = osc_sel_i & pad_in_i & {N{~blocked}};

  // Interrupt lines on the low pins bypass the input block when enabled
  assign ext_irq_o = ext_irq_en_i & pad_in_i[`SPSC_IRQ_N-1:0] &
                     {`SPSC_IRQ_N{~in_reset}};

  // ========================================================
  // Shared reset pin
  wire rst_as_port;
  assign rst_as_port            = rst_n_i & (mode_i == `SPSC_MODE_NORMAL);
  assign shared_reset_pin_oe_o  = rst_as_port & shared_reset_dir_i;
  assign shared_reset_pin_out_o = shared_reset_data_i;
  assign shared_reset_port_in_o = rst_as_port & shared_reset_pin_in_i;
  assign ext_reset_req_o        = ~rst_as_port & ~shared_reset_pin_in_i;

  // ========================================================
  // Debug wire, open-drain: only ever pulls low
  wire dbg_on;
  assign dbg_on               = debug_mode_i & rst_n_i;
  assign debug_wire_pin_out_o = 1'b0;
  assign debug_wire_pin_oe_o  = dbg_on & debug_tx_en_i & ~debug_tx_i;
  assign debug_rx_o           = dbg_on ? debug_wire_pin_in_i : 1'b1;
endmodule

// ==== spsc_top_chk.sv ====
// Purpose: Port-level checks for the standby pin state controller
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Entry checks look one cycle past the entry edge
`timescale 1ns/1ns
`include "spsc_defs.vh"
module spsc_top_chk #(
  parameter N = 8
) (
  input wire                    core_clk_i, rst_n_i, standby_float_select_i,
  input wire [`SPSC_MODE_W-1:0] mode_i,
  input wire [`SPSC_IRQ_N-1:0]  ext_irq_en_i, ext_irq_o,
  input wire [N-1:0]            dir_out_i, pullup_en_i, osc_sel_i, pad_in_i, pad_out_o,
  input wire [N-1:0]            pad_oe_o, pad_pullup_o, port_in_o, osc_in_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // Assertions
  sequence s_entry;
    mode_i[1] && !$past(mode_i[1]);
  endsequence
  AST_IN_BLOCK: assert property (mode_i[1] |-> port_in_o == 0)
    else $error("input not blocked in stop or watch");
  AST_HOLD: assert property (s_entry ##0 !standby_float_select_i ##1 mode_i[1] |->
    ((pad_oe_o ^ $past(dir_out_i)) & ~osc_sel_i & ~$past(osc_sel_i)) == 0)
    else $error("held drive lost after entry");
  AST_FLOAT: assert property (s_entry ##0 standby_float_select_i ##1 mode_i[1] |->
    pad_oe_o == 0 && ((pad_pullup_o ^ pullup_en_i) & ~osc_sel_i) == 0)
    else $error("pins not floated with pull-ups kept");
  AST_PU_LOW: assert property ((pad_pullup_o & pad_oe_o & ~pad_out_o) == 0)
    else $error("pull-up on while driving low");
  AST_IRQ: assert property (mode_i[1] |-> ext_irq_o == (pad_in_i[1:0] & ext_irq_en_i))
    else $error("interrupt line lost in standby");
  AST_RESET: assert property (disable iff (1'b0) !rst_n_i && !$past(rst_n_i) |->
    pad_oe_o == 0 && port_in_o == 0 && ext_irq_o == 0)
    else $error("pin active during reset");
  AST_OSC: assert property (mode_i[1] |-> osc_in_o == 0 && (pad_oe_o & osc_sel_i) == 0)
    else $error("oscillator pin active in standby");
  AST_WAKE: assert property (!mode_i[1] |-> ((pad_oe_o ^ dir_out_i) & ~osc_sel_i) == 0)
    else $error("drive not from direction setting");
endmodule
bind spsc_top spsc_top_chk #(.N(N)) u_chk (.*);

// ==== spsc_top_tb.sv ====
// Purpose: Self-checking bench for the standby pin state controller
// Assumes: Board levels change no faster than every two clocks
// Notes:   Mode walk in rows; pull-up, reset and debug by hand
`timescale 1ns/1ns
module spsc_top_tb;
  typedef struct packed {
    logic [1:0] md; logic sl; logic [7:0] dr, dt; logic [1:0] ie;
    logic [7:0] oe, pin; logic [1:0] irq;
  } spsc_row_t;
  spsc_row_t rows [6] = '{'{0,0,8'hf0,8'ha5,1,8'hf0,8'haf,1}, '{2,0,8'hf0,8'ha5,1,8'hf0,0,1},
    '{2,0,8'h0f,0,3,8'hf0,0,3}, '{0,0,8'h0f,0,3,8'h0f,8'hf0,0},
    '{3,1,8'h0f,8'h0f,3,0,0,3}, '{1,1,8'h0f,8'h0f,2,8'h0f,8'hff,2}};
  logic clk, rst_n, sl, dbg;
  logic [1:0] md, ie;
  logic [7:0] dr, dt, pu, osc, pad_in, pad_out_o, pad_oe_o, pad_pullup_o, port_in_o;
  logic [1:0] ext_irq_o;
  logic rr_o, dbg_oe_o, rpin;
  int bad_count, compares, cyc;
  spsc_top dut (.core_clk_i(clk), .rst_n_i(rst_n), .mode_i(md), .standby_float_select_i(sl),
    .dir_out_i(dr), .data_i(dt), .pullup_en_i(pu), .osc_sel_i(osc), .ext_irq_en_i(ie),
    .pad_in_i(pad_in), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pad_pullup_o(pad_pullup_o),
    .port_in_o(port_in_o), .osc_in_o(), .ext_irq_o(ext_irq_o), .shared_reset_pin_in_i(rpin),
    .shared_reset_dir_i(1'b0), .shared_reset_data_i(1'b0), .shared_reset_pin_out_o(),
    .shared_reset_pin_oe_o(), .shared_reset_port_in_o(), .ext_reset_req_o(rr_o),
    .debug_mode_i(dbg), .debug_wire_pin_in_i(1'b1), .debug_tx_i(1'b0), .debug_tx_en_i(dbg),
    .debug_wire_pin_out_o(), .debug_wire_pin_oe_o(dbg_oe_o), .debug_rx_o());
  // Board holds every level for at least two clocks
  spsc_pad_model pads (.clk_i(clk), .oe_i(pad_oe_o), .out_i(pad_out_o), .pu_i(pad_pullup_o),
    .ext_i(8'hff), .pad_o(pad_in));
  task chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task complete_run;
    if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      complete_run;
    end
  end
  initial begin
    {rst_n, sl, dbg, md, ie, dr, dt, pu, osc, rpin} = 0;
    step(12);
    rst_n <= 1;
    foreach (rows[i]) begin
      {md, sl, dr, dt, ie} <= rows[i][38:18];
      step(2);
      chk(pad_oe_o, rows[i].oe);
      chk(port_in_o, rows[i].pin);
      chk(8'(ext_irq_o), 8'(rows[i].irq));
      chk(8'(rr_o), 8'(md != 2'h0));
    end
    {md, dr, dt, pu, dbg} <= {2'h0, 8'hff, 8'h0f, 8'hff, 1'b1};
    step(2);
    chk(pad_pullup_o, 8'h0f);
    chk(8'(dbg_oe_o), 8'h01);
    {md, sl, osc, rpin} <= {2'h2, 1'b1, 8'h03, 1'b1};
    step(2);
    chk(pad_pullup_o & 8'hfc, 8'hfc);
    chk(8'(rr_o), 8'h00);
    rst_n <= 0;
    step(2);
    chk(pad_oe_o | port_in_o, 8'h00);
    complete_run;
  end
endmodule
